/* File: src/efp_frame_fifo.sv */
// How it works
// (R1) Never overlap transmit descriptor read and write-back.
// (R2) Each channel and direction carries its own ID.
// (R3) Packet data writes go out posted.
// (R4) Descriptor write-backs always go out non-posted.
// (R5) Error response disables channel, raises interrupt.
// (R6) Up to sixteen transactions outstanding.
// (R7) Cacheable setting changes only while port idle.
// (R8) 32-bit control slave plus 32-bit DMA master.
// (R9) One transmit, one receive FIFO, 1024x42.
// (R10) Entry: 32 data, 2 byte enables, EOF.
// (R11) Seven check bits give SECDED over entry.
// (R12) ECC enable, injection inputs, error status outputs.
// (R13) Cut-through transmit starts at threshold or EOF.
// (R14) Past 96/548 popped bytes, space freed, no retry. Here only in cut-through; store-forward keeps the frame and allows retry.
// (R15) Store-forward transmit starts on frame or almost-full.
// (R16) Flush bit empties transmit FIFO, self-clears.
// (R17) Flush mid-frame gives underflow and status.
// (R18) Collision retry pops the frame again.
// (R19) Software keeps frames to 3800 bytes with offload.
// (R20) Receive level reported on threshold crossing.
// (R21) Cut-through receive starts at 64 bytes or packet.
// (R22) Receive store-forward reads only whole frames.
// (R23) Receive overflow drops frame, counts it.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
module efp_frame_fifo #(
   parameter int DEPTH = efp_pkg::DEPTH,
   parameter int MAX_OUT = efp_pkg::MAX_OUTST
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [31:0] reg_rdata,
   input wire logic ecc_en,
   input wire logic ecc_inj_single,
   input wire logic ecc_inj_double,
   output logic ecc_corrected,
   output logic ecc_uncorrectable,
   input wire logic txw_valid,
   output logic txw_ready,
   input wire efp_pkg::efp_word_t txw_data,
   output logic txm_valid,
   input wire logic txm_ready,
   output efp_pkg::efp_word_t txm_data,
   input wire logic mac_gig,
   input wire logic mac_retry,
   output logic tx_underflow,
   input wire logic rxm_valid,
   input wire efp_pkg::efp_word_t rxm_data,
   output logic rxd_valid,
   input wire logic rxd_ready,
   output efp_pkg::efp_word_t rxd_data,
   output logic [15:0] rx_fill_level,
   output logic rx_level_hit,
   input wire logic dma_req_valid,
   output logic dma_req_ready,
   input wire efp_pkg::efp_dreq_t dma_req,
   output logic m_req_valid,
   input wire logic m_req_ready,
   output efp_pkg::efp_mreq_t m_req,
   input wire logic m_rsp_valid,
   input wire efp_pkg::efp_mrsp_t m_rsp,
   output logic dma_irq,
   output logic [3:0] chan_disabled
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_LVL = (AW + 1)'(DEPTH);
   localparam logic [AW:0] AF_LVL = (AW + 1)'(DEPTH - efp_pkg::TX_AF_MARGIN);

   typedef struct packed {
      logic [31:0] opmode;
      logic flush;
      logic srst;
      logic [AW:0] tx_wr;
      logic [AW:0] tx_rd;
      logic [AW:0] tx_cm;
      logic [AW:0] tx_frames;
      logic tx_act;
      logic tx_rel;
      logic [12:0] tx_cnt;
      logic tx_ov;
      efp_pkg::efp_word_t tx_od;
      logic tx_unf;
      logic [AW:0] rx_wr;
      logic [AW:0] rx_rd;
      logic [AW:0] rx_fs;
      logic [AW:0] rx_frames;
      logic rx_drop;
      logic rx_dummy;
      logic rx_act;
      logic rx_ov;
      efp_pkg::efp_word_t rx_od;
      logic [15:0] rx_lvl;
      logic rx_above;
      logic rx_hit;
      logic [15:0] missed;
      logic ecc_c;
      logic ecc_u;
      logic [4:0] outst;
      logic [7:0][4:0] idcnt;
      logic [3:0] dis;
      logic irq;
      logic [31:0] rdata;
   } efp_state_t;

   efp_state_t st;
   efp_state_t nx;
   logic [efp_pkg::CODE_BITS-1:0] tx_mem [DEPTH];
   logic [efp_pkg::CODE_BITS-1:0] rx_mem [DEPTH];

   ////////////////////////////////////////////////////////////////////////
   // Position p of the codeword holds a data bit unless p is a power of
   // two; bit 0 is overall parity, which splits single from double errors.
   function automatic logic [41:0] ecc_enc(input efp_pkg::efp_word_t d);
      logic [41:0] c;
      int k;
      c = '0;
      k = 0;
      for (int p = 1; p < 42; p++) begin
         if ((p & (p - 1)) != 0) begin
            c[p] = d[k];
            k++;
         end
      end
      for (int p = 3; p < 42; p++) begin
         for (int i = 0; i < 6; i++) begin
            if (p[i] && ((p & (p - 1)) != 0)) begin
               c[1 << i] = c[1 << i] ^ c[p];
            end
         end
      end
      c[0] = ^c[41:1];
      return c;
   endfunction

   function automatic efp_pkg::efp_dec_t ecc_dec(input logic [41:0] cw,
                                                 input logic en);
      efp_pkg::efp_dec_t r;
      logic [41:0] c;
      logic [5:0] syn;
      logic ovr;
      int k;
      r = '0;
      c = cw;
      syn = '0;
      k = 0;
      ovr = ^cw;
      for (int p = 1; p < 42; p++) begin
         if (c[p]) begin
            syn = syn ^ 6'(p);
         end
      end
      if (en && ovr && syn != 6'h0 && syn < 6'd42) begin
         c[syn] = !c[syn];
      end
      r.sbe = en && ovr;
      r.dbe = en && !ovr && (syn != 6'h0);
      for (int p = 1; p < 42; p++) begin
         if ((p & (p - 1)) != 0) begin
            r.w[k] = c[p];
            k++;
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [41:0] inj_mask;
   efp_pkg::efp_dec_t tx_dec;
   efp_pkg::efp_dec_t rx_dec;
   logic tx_push;
   logic tx_start;
   logic tx_sf;
   logic [12:0] tx_limit;
   logic [AW+2:0] tx_bytes;
   logic [9:0] ttc_bytes;
   logic [7:0] rtc_bytes;
   logic rx_full;
   logic rx_we;
   efp_pkg::efp_word_t rx_wd;
   logic rx_start;
   logic tx_finc;
   logic tx_fdec;
   logic rx_finc;
   logic rx_fdec;
   logic m_ok;
   logic [2:0] m_id;
   logic txd_conflict;
   logic issue;

   assign inj_mask = ecc_inj_double ? 42'h006 :
                     (ecc_inj_single ? 42'h002 : 42'h000); // see R12
   assign tx_dec = ecc_dec(tx_mem[st.tx_rd[AW-1:0]], ecc_en); // see R11
   assign rx_dec = ecc_dec(rx_mem[st.rx_rd[AW-1:0]], ecc_en);
   assign tx_sf = st.opmode[efp_pkg::TX_SF_BIT];
   assign ttc_bytes = {st.opmode[efp_pkg::TTC_LSB +: 3], 6'h00} + 10'h040;
   assign rtc_bytes = {st.opmode[efp_pkg::RTC_LSB +: 2], 5'h00} + 8'h20;
   assign tx_limit = mac_gig ? 13'(efp_pkg::RETRY_BYTES_GIG) :
                     13'(efp_pkg::RETRY_BYTES);
   assign tx_bytes = {st.tx_wr - st.tx_rd, 2'b00};
   // Freed space is counted from the commit point, so retry data stays safe.
   assign txw_ready = ((st.tx_wr - st.tx_cm) < FULL_LVL) && !st.flush;
   assign tx_push = txw_valid && txw_ready;
   assign tx_start = tx_sf ?
      (st.tx_frames != '0 || (st.tx_wr - st.tx_cm) >= AF_LVL) : // see R15
      (tx_bytes >= (AW + 3)'(ttc_bytes) || st.tx_frames != '0); // see R13
   assign rx_full = (st.rx_wr - st.rx_rd) == FULL_LVL;
   assign rx_start = st.rx_frames != '0 ||
      (!st.opmode[efp_pkg::RSF_BIT] && // see R22
       {st.rx_wr - st.rx_rd, 2'b00} >= (AW + 3)'(efp_pkg::RX_CT_BYTES)); // see R21

   // A transmit descriptor request waits while the opposite direction of
   // the same channel is still in flight.
   assign m_id = {dma_req.chan, dma_req.write}; // see R2
   assign txd_conflict = (dma_req.chan == efp_pkg::CH_TXDESC) &&
      (st.idcnt[{efp_pkg::CH_TXDESC, !dma_req.write}] != 5'h0); // see R1
   assign m_ok = !st.dis[dma_req.chan] && !txd_conflict &&
      (st.outst < 5'(MAX_OUT)); // see R6
   assign m_req_valid = dma_req_valid && m_ok;
   assign dma_req_ready = m_req_ready && m_ok;
   assign m_req.id = m_id;
   assign m_req.write = dma_req.write;
   assign m_req.posted = dma_req.write && dma_req.chan[1]; // see R3 see R4
   assign issue = m_req_valid && m_req_ready;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nx = st;
      nx.flush = 1'b0;
      nx.srst = 1'b0;
      nx.tx_unf = 1'b0;
      nx.rx_hit = 1'b0;
      nx.ecc_c = 1'b0;
      nx.ecc_u = 1'b0;
      nx.rdata = '0;
      tx_finc = tx_push && txw_data.eof;
      tx_fdec = 1'b0;
      rx_finc = 1'b0;
      rx_fdec = 1'b0;
      rx_we = 1'b0;
      rx_wd = rxm_data;
      if (reg_we) begin
         case (reg_addr)
            efp_pkg::REG_OPMODE: begin
               nx.opmode = reg_wdata;
               nx.opmode[efp_pkg::FLUSH_BIT] = 1'b0;
               nx.flush = reg_wdata[efp_pkg::FLUSH_BIT]; // see R16
            end
            efp_pkg::REG_BUSMODE: nx.srst = reg_wdata[efp_pkg::SOFT_RST_BIT];
            default: ;
         endcase
      end
      if (reg_re) begin
         case (reg_addr)
            efp_pkg::REG_OPMODE:
               nx.rdata = st.opmode | (32'(st.flush) << efp_pkg::FLUSH_BIT);
            efp_pkg::REG_BUSMODE: nx.rdata = 32'(st.srst);
            efp_pkg::REG_MISSED: nx.rdata = 32'(st.missed);
            efp_pkg::REG_STATUS:
               nx.rdata = {20'h0, st.rx_drop, st.tx_act, st.irq, st.dis,
                           st.outst};
            default: nx.rdata = '0;
         endcase
      end
      // Transmit side.
      if (tx_push) begin
         nx.tx_wr = st.tx_wr + 1'b1;
      end
      if (mac_retry && st.tx_act && !st.tx_rel) begin
         nx.tx_rd = st.tx_cm; // see R18
         nx.tx_ov = 1'b0;
         nx.tx_cnt = '0;
      end else begin
         if (!st.tx_act && st.tx_rd != st.tx_wr && tx_start) begin
            nx.tx_act = 1'b1;
         end
         if (!st.tx_ov || txm_ready) begin
            nx.tx_ov = 1'b0;
            if (st.tx_act && st.tx_rd != st.tx_wr) begin
               nx.tx_ov = 1'b1;
               nx.tx_od = tx_dec.w;
               nx.ecc_c = tx_dec.sbe;
               nx.ecc_u = tx_dec.dbe;
               nx.tx_rd = st.tx_rd + 1'b1;
               nx.tx_cnt = st.tx_cnt + 13'h004;
               if (tx_dec.w.eof) begin
                  nx.tx_act = 1'b0;
                  nx.tx_cm = st.tx_rd + 1'b1;
                  nx.tx_cnt = '0;
                  nx.tx_rel = 1'b0;
                  tx_fdec = 1'b1;
               end else if (!tx_sf && st.tx_cnt + 13'h004 > tx_limit) begin
                  nx.tx_rel = 1'b1; // see R14
                  nx.tx_cm = st.tx_rd + 1'b1;
               end
            end
         end
      end
      nx.tx_frames = st.tx_frames + (AW + 1)'(tx_finc) - (AW + 1)'(tx_fdec);
      if (st.flush) begin
         nx.tx_wr = '0; // see R16
         nx.tx_rd = '0;
         nx.tx_cm = '0;
         nx.tx_frames = '0;
         nx.tx_act = 1'b0;
         nx.tx_ov = 1'b0;
         nx.tx_rel = 1'b0;
         nx.tx_cnt = '0;
         nx.tx_unf = st.tx_act; // see R17
      end
      // Receive side. A pending dummy end marker goes in before anything
      // else; data arriving meanwhile is dropped, a deliberate limitation.
      if (st.rx_dummy && !rx_full) begin
         rx_we = 1'b1;
         rx_wd = '{data: efp_pkg::RX_OVF_STATUS, be: 2'h3, eof: 1'b1};
         nx.rx_wr = st.rx_wr + 1'b1;
         nx.rx_fs = st.rx_wr + 1'b1;
         nx.rx_dummy = 1'b0;
         rx_finc = 1'b1;
      end
      if (rxm_valid) begin
         if (st.rx_drop || st.rx_dummy) begin
            nx.rx_drop = !(rxm_data.eof && !st.rx_dummy);
         end else if (rx_full) begin
            nx.missed = st.missed + 16'h0001; // see R23
            nx.rx_drop = !rxm_data.eof;
            // If the reader is already inside this frame it cannot be
            // rewound, so the frame is closed with an overflow status.
            if (st.rx_act && st.rx_frames == '0) begin
               nx.rx_dummy = 1'b1;
            end else begin
               nx.rx_wr = st.rx_fs;
            end
         end else begin
            rx_we = 1'b1;
            nx.rx_wr = st.rx_wr + 1'b1;
            if (rxm_data.eof) begin
               nx.rx_fs = st.rx_wr + 1'b1;
               rx_finc = 1'b1;
            end
         end
      end
      if (!st.rx_act && st.rx_rd != st.rx_wr && rx_start) begin
         nx.rx_act = 1'b1;
      end
      if (!st.rx_ov || rxd_ready) begin
         nx.rx_ov = 1'b0;
         if (st.rx_act && st.rx_rd != st.rx_wr) begin
            nx.rx_ov = 1'b1; // see R21
            nx.rx_od = rx_dec.w;
            nx.ecc_c = nx.ecc_c || rx_dec.sbe;
            nx.ecc_u = nx.ecc_u || rx_dec.dbe;
            nx.rx_rd = st.rx_rd + 1'b1;
            if (rx_dec.w.eof) begin
               nx.rx_act = 1'b0;
               rx_fdec = 1'b1;
            end
         end
      end
      nx.rx_frames = st.rx_frames + (AW + 1)'(rx_finc) - (AW + 1)'(rx_fdec);
      nx.rx_lvl = 16'(st.rx_wr - st.rx_rd);
      nx.rx_above = {st.rx_lvl, 2'b00} >= 18'(rtc_bytes);
      nx.rx_hit = nx.rx_above && !st.rx_above; // see R20
      // DMA master port bookkeeping.
      if (issue) begin
         nx.outst = nx.outst + 5'h01;
         nx.idcnt[m_id] = nx.idcnt[m_id] + 5'h01;
      end
      if (m_rsp_valid) begin
         nx.outst = nx.outst - 5'h01;
         nx.idcnt[m_rsp.id] = nx.idcnt[m_rsp.id] - 5'h01;
         if (m_rsp.err) begin
            nx.dis[m_rsp.id[2:1]] = 1'b1; // see R5
            nx.irq = 1'b1;
         end
      end
      if (st.srst) begin
         nx = '0;
         nx.opmode = efp_pkg::OPMODE_RST;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   // Memories carry no reset; pointers guard every read.
   always_ff @(posedge core_clk) begin
      if (tx_push) begin
         tx_mem[st.tx_wr[AW-1:0]] <= ecc_enc(txw_data) ^ inj_mask; // see R10
      end
      if (rx_we) begin
         rx_mem[st.rx_wr[AW-1:0]] <= ecc_enc(rx_wd) ^ inj_mask; // see R9
      end
   end

   assign reg_rdata = st.rdata; // see R8
   assign ecc_corrected = st.ecc_c;
   assign ecc_uncorrectable = st.ecc_u;
   assign txm_valid = st.tx_ov;
   assign txm_data = st.tx_od;
   assign tx_underflow = st.tx_unf;
   assign rxd_valid = st.rx_ov;
   assign rxd_data = st.rx_od;
   assign rx_fill_level = st.rx_lvl;
   assign rx_level_hit = st.rx_hit;
   assign dma_irq = st.irq;
   assign chan_disabled = st.dis;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   property p_txd_overlap;
      issue && m_req.id[2:1] == efp_pkg::CH_TXDESC |->
         st.idcnt[{efp_pkg::CH_TXDESC, !m_req.write}] == 5'h0;
   endproperty
   a_txd_overlap: assert property (p_txd_overlap) // see R1
      else $error("tx descriptor read and write-back overlap");

   property p_posted;
      m_req_valid && m_req.write |->
         m_req.posted == (m_req.id[2:1] == efp_pkg::CH_TXPKT ||
                          m_req.id[2:1] == efp_pkg::CH_RXPKT);
   endproperty
   a_posted: assert property (p_posted) // see R4
      else $error("wrong posted attribute on write");

   property p_err_disable;
      m_rsp_valid && m_rsp.err && !st.srst |=>
         chan_disabled[$past(m_rsp.id[2:1])] && dma_irq;
   endproperty
   a_err_disable: assert property (p_err_disable) // see R5
      else $error("error response did not disable channel");

   property p_dis_blocks;
      dma_req_valid && st.dis[dma_req.chan] |-> !m_req_valid;
   endproperty
   a_dis_blocks: assert property (p_dis_blocks) // see R5
      else $error("disabled channel issued a request");

   property p_outst;
      st.outst == 5'(MAX_OUT) |-> !m_req_valid;
   endproperty
   a_outst: assert property (p_outst) // see R6
      else $error("more than allowed outstanding");

   property p_flush;
      reg_we && reg_addr == efp_pkg::REG_OPMODE &&
         reg_wdata[efp_pkg::FLUSH_BIT] |=>
         st.flush ##1 (!st.flush && st.tx_wr == '0 && !txm_valid);
   endproperty
   a_flush: assert property (p_flush) // see R16
      else $error("flush did not empty transmit fifo");

   property p_flush_unf;
      st.flush && st.tx_act && !st.srst |=> tx_underflow;
   endproperty
   a_flush_unf: assert property (p_flush_unf) // see R17
      else $error("flush mid-frame gave no underflow");

   property p_release;
      $rose(st.tx_rel) |-> $past(st.tx_cnt) + 13'h004 > $past(tx_limit);
   endproperty
   a_release: assert property (p_release) // see R14
      else $error("transmit space released too early");

   property p_rx_sf;
      !st.rx_act && nx.rx_act && st.opmode[efp_pkg::RSF_BIT] |->
         st.rx_frames != '0;
   endproperty
   a_rx_sf: assert property (p_rx_sf) // see R22
      else $error("store-forward read before whole frame");

   property p_overflow;
      rxm_valid && rx_full && !st.rx_drop && !st.rx_dummy && !st.srst |=>
         st.missed == $past(st.missed) + 16'h0001;
   endproperty
   a_overflow: assert property (p_overflow) // see R23
      else $error("overflow not counted");

   c_retry: cover property (mac_retry && st.tx_act && !st.tx_rel);
   c_flush_mid: cover property (st.flush && st.tx_act);
   c_overflow: cover property (rxm_valid && rx_full && !st.rx_drop);
   c_err: cover property (m_rsp_valid && m_rsp.err);
endmodule // efp_frame_fifo

/* File: src/efp_pkg.sv */
package efp_pkg;
   localparam int DEPTH = 1024;
   localparam int CODE_BITS = 42;
   localparam int MAX_OUTST = 16;
   // Register byte addresses on the 32-bit control port.
   localparam logic [7:0] REG_BUSMODE = 8'h00;
   localparam logic [7:0] REG_OPMODE = 8'h18;
   localparam logic [7:0] REG_MISSED = 8'h20;
   localparam logic [7:0] REG_STATUS = 8'h40;
   localparam int SOFT_RST_BIT = 0;
   localparam int RTC_LSB = 3;
   localparam int TTC_LSB = 14;
   localparam int FLUSH_BIT = 20;
   localparam int TX_SF_BIT = 21;
   localparam int RSF_BIT = 25;
   localparam logic [31:0] OPMODE_RST = 32'h0000_0000;
   localparam int RETRY_BYTES = 96;
   localparam int RETRY_BYTES_GIG = 548;
   localparam int RX_CT_BYTES = 64;
   localparam int TX_AF_MARGIN = 16;
   localparam logic [31:0] RX_OVF_STATUS = 32'h0000_0001;
   localparam logic [1:0] CH_TXDESC = 2'h0;
   localparam logic [1:0] CH_RXDESC = 2'h1;
   localparam logic [1:0] CH_TXPKT = 2'h2;
   localparam logic [1:0] CH_RXPKT = 2'h3;

   typedef struct packed {
      logic [31:0] data;
      logic [1:0] be;
      logic eof;
   } efp_word_t;

   typedef struct packed {
      efp_word_t w;
      logic sbe;
      logic dbe;
   } efp_dec_t;

   typedef struct packed {
      logic [1:0] chan;
      logic write;
   } efp_dreq_t;

   typedef struct packed {
      logic [2:0] id;
      logic write;
      logic posted;
   } efp_mreq_t;

   typedef struct packed {
      logic [2:0] id;
      logic err;
   } efp_mrsp_t;

   typedef struct packed {
      logic [19:0] zero;
      logic rx_drop;
      logic tx_act;
      logic irq;
      logic [3:0] dis;
      logic [4:0] outst;
   } efp_status_t;
endpackage

/* File: tb/efp_bus_model.sv */
module efp_bus_model (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic m_req_valid,
   input wire efp_pkg::efp_mreq_t m_req,
   output logic m_req_ready,
   output logic m_rsp_valid,
   output efp_pkg::efp_mrsp_t m_rsp,
   input wire logic stall,
   input wire logic err_next
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] pend[$];

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pend.delete();
         m_req_ready <= 1'b0;
         m_rsp_valid <= 1'b0;
         m_rsp <= '0;
      end else begin
         m_req_ready <= 1'b1;
         m_rsp_valid <= 1'b0;
         m_rsp <= ~m_rsp;
         if (m_req_valid && m_req_ready) pend.push_back(m_req.id);
         if (!stall && pend.size() > 0) begin
            m_rsp_valid <= 1'b1;
            m_rsp <= {pend.pop_front(), err_next};
         end
      end
   end
endmodule // efp_bus_model

/* File: tb/emac_frame_fifo_dma_port_tb_top.sv */
module emac_frame_fifo_dma_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, arst_n, reg_we, reg_re, ecc_en, ecc_inj_single;
   logic ecc_inj_double, ecc_corrected, ecc_uncorrectable, txw_valid;
   logic txw_ready, txm_valid, txm_ready, mac_gig, mac_retry;
   logic tx_underflow, rxm_valid, rxd_valid, rxd_ready, rx_level_hit;
   logic dma_req_valid, dma_req_ready, m_req_valid, m_req_ready;
   logic m_rsp_valid, dma_irq, stall, err_next;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic [15:0] rx_fill_level;
   logic [3:0] chan_disabled;
   efp_pkg::efp_word_t txw_data, txm_data, rxm_data, rxd_data;
   efp_pkg::efp_dreq_t dma_req;
   efp_pkg::efp_mreq_t m_req;
   efp_pkg::efp_mrsp_t m_rsp;
   int fail_count, cmp_count, cyc, n_cor, n_unc, n_unf, n_hit, wcnt;
   logic [31:0] tx_got[$], rx_got[$], exp_q[$];
   logic [7:0] ra[5] = '{8'h00, 8'h18, 8'h20, 8'h40, 8'h7c};

   efp_frame_fifo dut (.*);
   efp_bus_model far_end (.*);

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (txm_valid === 1'b1 && txm_ready === 1'b1)
         tx_got.push_back(txm_data.data);
      if (rxd_valid === 1'b1 && rxd_ready === 1'b1)
         rx_got.push_back(rxd_data.data);
      n_cor += int'(ecc_corrected === 1'b1);
      n_unc += int'(ecc_uncorrectable === 1'b1);
      n_unf += int'(tx_underflow === 1'b1);
      n_hit += int'(rx_level_hit === 1'b1);
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d fails %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic fin(input string s);
      $display("%s done", s);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge core_clk);
      reg_we <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge core_clk);
      reg_re <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
      @(posedge core_clk);
   endtask

   function automatic int got(input logic rx);
      return rx ? rx_got.size() : tx_got.size();
   endfunction

   task automatic clear();
      tx_got.delete();
      rx_got.delete();
      exp_q.delete();
   endtask

   // Frames stay short, except the receive overflow frame of DEPTH + 5 words.
   task automatic push(input logic rx, input int n, input logic last);
      efp_pkg::efp_word_t w;
      for (int i = 0; i < n; i++) begin
         w = {32'h0a00_0000 + 32'(wcnt), 2'h3, last && i == n - 1};
         exp_q.push_back(w.data);
         wcnt++;
         if (rx) begin
            rxm_valid <= 1'b1;
            rxm_data <= w;
            @(posedge core_clk);
         end else begin
            txw_valid <= 1'b1;
            txw_data <= w;
            do @(posedge core_clk); while (txw_ready !== 1'b1);
         end
      end
      rxm_valid <= 1'b0;
      txw_valid <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic drain(input logic rx);
      txm_ready <= 1'b1;
      rxd_ready <= 1'b1;
      for (int k = 0; k < 300 && got(rx) < exp_q.size(); k++)
         @(posedge core_clk);
      tick(2);
      check(got(rx), exp_q.size());
      foreach (exp_q[i]) begin
         check(rx ? rx_got[i] : tx_got[i], exp_q[i]);
      end
      clear();
   endtask

   task automatic gate(input logic rx, input logic [31:0] opm, input int n,
      input logic sf);
      reg_wr(efp_pkg::REG_OPMODE, opm);
      txm_ready <= 1'b0;
      rxd_ready <= 1'b0;
      n_hit = 0;
      push(rx, n, 1'b0);
      tick(8);
      check(rx ? rxd_valid : txm_valid, 1'b0);
      push(rx, 1, sf);
      tick(8);
      check(rx ? rxd_valid : txm_valid, 1'b1);
      if (rx) check(n_hit, 1);
      if (!sf) push(rx, 1, 1'b1);
      drain(rx);
   endtask

   task automatic retry(input logic gig, input int n, input int k,
      input logic again);
      mac_gig <= gig;
      txm_ready <= 1'b0;
      push(1'b0, n, 1'b1);
      txm_ready <= 1'b1;
      for (int j = 0; j < 200 && tx_got.size() < k; j++)
         @(posedge core_clk);
      mac_retry <= 1'b1;
      @(posedge core_clk);
      mac_retry <= 1'b0;
      tick(n + 40);
      check(tx_got.size() > n, again);
      for (int i = 0; i < n; i++) begin
         check(tx_got[tx_got.size() - n + i], exp_q[i]);
      end
      clear();
   endtask

   task automatic issue(input logic [1:0] ch, input logic wr);
      dma_req_valid <= 1'b1;
      dma_req <= {ch, wr};
      for (int k = 0; k < 40; k++) begin
         @(posedge core_clk);
         if (m_req_valid === 1'b1 && m_req_ready === 1'b1) break;
      end
      check({m_req_valid, m_req}, {1'b1, ch, wr, wr, wr & ch[1]});
   endtask

   task automatic blocked(input logic [1:0] ch, input logic wr);
      dma_req_valid <= 1'b1;
      dma_req <= {ch, wr};
      tick(6);
      check(m_req_valid, 1'b0);
   endtask

   // The cacheable setting is never touched.
   task automatic idle();
      dma_req_valid <= 1'b0;
      tick(24);
   endtask

   task automatic soft_reset();
      reg_wr(efp_pkg::REG_BUSMODE, 32'h0000_0001);
      tick(3);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      {arst_n, reg_we, reg_re, ecc_en, ecc_inj_single, ecc_inj_double} = '0;
      {txw_valid, txm_ready, mac_gig, mac_retry, rxm_valid, rxd_ready} = '0;
      {dma_req_valid, stall, err_next, reg_addr, reg_wdata} = '0;
      {txw_data, rxm_data, dma_req} = '0;
      tick(12);
      arst_n <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 5; i++) begin
         reg_rd(ra[i], rd);
         check(rd, 32'h0);
      end
      reg_wr(efp_pkg::REG_OPMODE, 32'h0220_4018);
      reg_rd(efp_pkg::REG_OPMODE, rd);
      check(rd, 32'h0220_4018);
      reg_wr(efp_pkg::REG_MISSED, 32'h0000_ffff);
      reg_rd(efp_pkg::REG_MISSED, rd);
      check(rd, 32'h0);
      fin("registers");
      gate(1'b0, 32'h0000_4000, 31, 1'b0);
      gate(1'b0, 32'h0020_0000, 39, 1'b1);
      gate(1'b1, 32'h0000_0000, 15, 1'b0);
      gate(1'b1, 32'h0200_0000, 30, 1'b1);
      fin("start conditions");
      reg_wr(efp_pkg::REG_OPMODE, 32'h0);
      retry(1'b0, 20, 5, 1'b1);
      retry(1'b0, 40, 30, 1'b0);
      retry(1'b1, 40, 30, 1'b1);
      fin("retry");
      ecc_en <= 1'b1;
      ecc_inj_single <= 1'b1;
      push(1'b0, 4, 1'b1);
      ecc_inj_single <= 1'b0;
      drain(1'b0);
      check(n_cor, 4);
      txm_ready <= 1'b0;
      push(1'b0, 20, 1'b0);
      txm_ready <= 1'b1;
      tick(3);
      txm_ready <= 1'b0;
      reg_wr(efp_pkg::REG_OPMODE, 32'h0010_0000);
      tick(3);
      check(n_unf, 1);
      check(txm_valid, 1'b0);
      reg_rd(efp_pkg::REG_OPMODE, rd);
      check(rd, 32'h0);
      clear();
      push(1'b0, 19, 1'b0);
      ecc_inj_double <= 1'b1;
      push(1'b0, 1, 1'b1);
      ecc_inj_double <= 1'b0;
      txm_ready <= 1'b1;
      tick(40);
      check(n_unc, 1);
      soft_reset();
      reg_rd(efp_pkg::REG_STATUS, rd);
      check(rd & 32'h0000_07ff, 32'h0);
      clear();
      fin("ecc and flush");
      reg_wr(efp_pkg::REG_OPMODE, 32'h0200_0000);
      rxd_ready <= 1'b0;
      push(1'b1, efp_pkg::DEPTH + 4, 1'b0);
      push(1'b1, 1, 1'b1);
      reg_rd(efp_pkg::REG_MISSED, rd);
      check(rd, 32'h1);
      clear();
      push(1'b1, 3, 1'b1);
      drain(1'b1);
      fin("overflow");
      for (int c = 0; c < 8; c++) issue(2'(c / 2), 1'(c % 2));
      idle();
      stall <= 1'b1;
      issue(2'h0, 1'b0);
      blocked(2'h0, 1'b1);
      stall <= 1'b0;
      issue(2'h0, 1'b1);
      idle();
      stall <= 1'b1;
      repeat (16) issue(2'h3, 1'b0);
      blocked(2'h3, 1'b0);
      reg_rd(efp_pkg::REG_STATUS, rd);
      check(rd & 32'h1f, 32'h10);
      stall <= 1'b0;
      issue(2'h3, 1'b0);
      idle();
      err_next <= 1'b1;
      issue(2'h2, 1'b1);
      idle();
      err_next <= 1'b0;
      check({dma_irq, chan_disabled}, 5'h14);
      blocked(2'h2, 1'b1);
      idle();
      soft_reset();
      check({dma_irq, chan_disabled}, 5'h00);
      issue(2'h2, 1'b1);
      idle();
      fin("master port");
      print_verdict();
   end
endmodule // emac_frame_fifo_dma_port_tb_top
